//--- rtl/i2cbc_defines.vh
// constants for the two-wire bus control register block
// assumes 32-bit apb with the control register alone in its own word
`ifndef I2CBC_DEFINES_VH
`define I2CBC_DEFINES_VH
`define I2CBC_OFF_CTRL     12'h000
`define I2CBC_OFF_EVENT    12'h004
`define I2CBC_CTRL_RESET   8'h01
`define I2CBC_BIT_ICE      7
`define I2CBC_BIT_IRQEN    6
`define I2CBC_BIT_MST      5
`define I2CBC_BIT_TRS      4
`define I2CBC_BIT_ACK_JUDGE_ENABLE     3
`define I2CBC_BIT_BUS_BUSY_FLAG     2
`define I2CBC_BIT_IRQ      1
`define I2CBC_BIT_SCP      0
`define I2CBC_MODE_SRX     2'b00
`define I2CBC_MODE_STX     2'b01
`define I2CBC_MODE_MRX     2'b10
`define I2CBC_MODE_MTX     2'b11
`endif

//--- rtl/i2cbc_ctrl.v
// bus control register of the two-wire interface with apb slave
// assumes scl/sda inputs synchronous to pclk; engine events as pulses
// Behaviour
// - interrupt out only while enable is set
// - mode pair decodes to four modes
// - arbitration loss clears master and transmit
// - slave receive takes transmit from r/w
// - transmit change inside a frame waits for frame end
// - judge off ignores ack, status zero
// - judge on halts transfer on nack
// - busy flag readable in slave mode
// - start condition sets busy flag
// - stop condition clears busy flag
// - slave mode busy writes ignored
// - repeated start uses same write
// - prohibit bit gates start/stop generation
// - request clears on zero after one read
// - nack with judge sets status, request
`timescale 1ns/1ps
`include "i2cbc_defines.vh"
module i2cbc_ctrl (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        scl_in,
  input  wire        sda_in,
  input  wire        arb_lost,
  input  wire        first_frame_done,
  input  wire        rw_bit,
  input  wire        frame_done,
  input  wire        ack_valid,
  input  wire        ack_in,
  input  wire        irq_event,
  output wire        irq,
  output wire [1:0]  mode,
  output wire        gen_start,
  output wire        gen_stop,
  output wire        transfer_halt,
  output wire        ack_received_bit,
  output wire        bus_busy_flag
);
  reg       ice_q;
  reg       irq_enable_q;
  reg       master_select_q;
  reg       transmit_select_q;
  reg       trs_pend_q;
  reg       trs_pend_val_q;
  reg       ack_judge_enable_q;
  reg       ack_q;
  reg       bus_busy_flag_q;
  reg       irq_request_flag_q;
  reg       irq_seen_q;
  reg       hw_mod_q;
  reg       mode_read_q;
  reg       halt_q;
  reg       start_q;
  reg       stop_q;
  reg       scl_prev_q;
  reg       sda_prev_q;
  reg       in_frame_q;

  function [31:0] ctrl_word;
    input [7:0] v;
    begin
      ctrl_word = {24'h000000, v};
    end
  endfunction

  wire       acc     = psel & penable;
  wire       wr      = acc & pwrite;
  wire       rd      = acc & ~pwrite;
  wire       hit     = (paddr == `I2CBC_OFF_CTRL);
  wire       hit_ev  = (paddr == `I2CBC_OFF_EVENT);
  wire       wr_ctrl = wr & hit;
  wire       rd_ctrl = rd & hit;
  wire [7:0] wd      = pwdata[7:0];
  wire       start_seen = scl_in & scl_prev_q & sda_prev_q & ~sda_in;
  wire       stop_seen  = scl_in & scl_prev_q & ~sda_prev_q & sda_in;
  wire       mst_wr  = wd[`I2CBC_BIT_MST];
  wire       trs_wr  = wd[`I2CBC_BIT_TRS];
  wire       nack    = ack_valid & ack_judge_enable_q & ack_in;
  // mode bits accept software only after a read following a hw change
  wire       mode_ok = ~hw_mod_q | mode_read_q;
  wire [7:0] ctrl_rd;

  assign pready  = 1'b1;
  assign pslverr = acc & ~hit & ~hit_ev;

  assign ctrl_rd = {ice_q, irq_enable_q, master_select_q,
                    transmit_select_q, ack_judge_enable_q, bus_busy_flag_q,
                    irq_request_flag_q, 1'b1};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_in;
      sda_prev_q <= sda_in;
    end
  end

  // read data is taken in setup so it stands through the access cycle
  wire       rd_setup  = psel & ~penable & ~pwrite;
  // flag value that software has actually been shown
  wire       irq_shown = prdata[`I2CBC_BIT_IRQ];
  wire       irq_clr   = wr_ctrl & irq_seen_q & ~wd[`I2CBC_BIT_IRQ];
  wire       trs_defer = in_frame_q & ~frame_done &
                         (trs_wr != transmit_select_q);
  // mode is the one before this write lands
  wire       cond_ok   = wr_ctrl & master_select_q & ~wd[`I2CBC_BIT_SCP];

  // apb read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      if (hit) begin
        prdata <= ctrl_word(ctrl_rd);
      end else begin
        // unmapped and reserved words read as zero
        prdata <= 32'h00000000;
      end
    end
  end

  // plain software control bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ice_q              <= 1'b0;
      irq_enable_q       <= 1'b0;
      ack_judge_enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      ice_q              <= wd[`I2CBC_BIT_ICE];
      irq_enable_q       <= wd[`I2CBC_BIT_IRQEN];
      ack_judge_enable_q <= wd[`I2CBC_BIT_ACK_JUDGE_ENABLE];
    end
  end

  // frame window, open from start to stop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame_q <= 1'b0;
    end else if (start_seen) begin
      in_frame_q <= 1'b1;
    end else if (stop_seen) begin
      in_frame_q <= 1'b0;
    end
  end

  // mode pair with its hardware overrides
  // overrides stand last so they win over a same-cycle write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_select_q   <= 1'b0;
      transmit_select_q <= 1'b0;
      trs_pend_q        <= 1'b0;
      trs_pend_val_q    <= 1'b0;
      hw_mod_q          <= 1'b0;
      mode_read_q       <= 1'b0;
    end else begin
      if (rd_ctrl) begin
        mode_read_q <= 1'b1;
      end
      if (wr_ctrl & mode_ok) begin
        master_select_q <= mst_wr;
        hw_mod_q        <= 1'b0;
        if (trs_defer) begin
          trs_pend_q     <= 1'b1;
          trs_pend_val_q <= trs_wr;
        end else begin
          transmit_select_q <= trs_wr;
          trs_pend_q        <= 1'b0;
        end
      end
      if (trs_pend_q & frame_done) begin
        transmit_select_q <= trs_pend_val_q;
        trs_pend_q        <= 1'b0;
      end
      if (first_frame_done & ~master_select_q & ~transmit_select_q) begin
        transmit_select_q <= rw_bit;
        hw_mod_q          <= 1'b1;
        mode_read_q       <= 1'b0;
      end
      if (arb_lost & master_select_q) begin
        master_select_q   <= 1'b0;
        transmit_select_q <= 1'b0;
        trs_pend_q        <= 1'b0;
        hw_mod_q          <= 1'b1;
        mode_read_q       <= 1'b0;
      end
    end
  end

  // start and stop requests, one-cycle pulses to the engine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      stop_q  <= 1'b0;
    end else begin
      start_q <= 1'b0;
      stop_q  <= 1'b0;
      if (cond_ok) begin
        if (wd[`I2CBC_BIT_BUS_BUSY_FLAG]) begin
          start_q <= 1'b1;
        end else begin
          stop_q <= 1'b1;
        end
      end
    end
  end

  // busy flag follows the lines only, never a write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_busy_flag_q <= 1'b0;
    end else begin
      if (start_seen) begin
        bus_busy_flag_q <= 1'b1;
      end else if (stop_seen) begin
        bus_busy_flag_q <= 1'b0;
      end
    end
  end

  // acknowledge judgement
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q  <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      if (!ack_judge_enable_q) begin
        ack_q  <= 1'b0;
        halt_q <= 1'b0;
      end else if (ack_valid) begin
        ack_q  <= ack_in;
        halt_q <= ack_in;
      end else if (start_seen) begin
        // a new start resumes transfer
        halt_q <= 1'b0;
      end
    end
  end

  // interrupt request flag, read then clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request_flag_q <= 1'b0;
      irq_seen_q         <= 1'b0;
    end else begin
      if (irq_event | nack) begin
        irq_request_flag_q <= 1'b1;
        // a new event must be read again before it can be cleared
        irq_seen_q         <= 1'b0;
      end else if (irq_clr) begin
        irq_request_flag_q <= 1'b0;
        irq_seen_q         <= 1'b0;
      end else if (rd_ctrl & irq_shown) begin
        irq_seen_q         <= 1'b1;
      end
    end
  end

  assign irq              = irq_enable_q & irq_request_flag_q;
  assign mode             = {master_select_q, transmit_select_q};
  assign gen_start        = start_q;
  assign gen_stop         = stop_q;
  assign transfer_halt    = halt_q;
  assign ack_received_bit = ack_q;
  assign bus_busy_flag    = bus_busy_flag_q;
endmodule

//--- tb/i2cbc_props.sv
// assertions on the bus control block ports
// bound to every i2cbc_ctrl instance below
`timescale 1ns/1ps
module i2cbc_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] pwdata,
  input logic        scl_in,
  input logic        sda_in,
  input logic        arb_lost,
  input logic        first_frame_done,
  input logic        rw_bit,
  input logic        ack_valid,
  input logic        ack_in,
  input logic        gen_start,
  input logic        gen_stop,
  input logic        transfer_halt,
  input logic        ack_received_bit,
  input logic        bus_busy_flag,
  input logic [1:0]  mode
);
  wire wr = psel & penable & pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_start; scl_in && $past(scl_in) && $fell(sda_in); endsequence
  sequence s_stop; scl_in && $past(scl_in) && $rose(sda_in); endsequence
  property p_bsy_set; s_start |-> ##[1:2] bus_busy_flag; endproperty
  property p_bsy_clr; s_stop |-> ##[1:2] !bus_busy_flag; endproperty
  property p_arb; arb_lost && mode[1] |=> mode == 2'h0; endproperty
  property p_rw; first_frame_done && mode == 2'h0 && !arb_lost
    |=> mode[0] == $past(rw_bit); endproperty
  property p_nack; $rose(ack_received_bit) |-> $past(ack_valid & ack_in);
  endproperty
  property p_halt; $rose(transfer_halt) |-> $past(ack_valid & ack_in);
  endproperty
  property p_start; gen_start |-> $past(wr & pwdata[2] & ~pwdata[0]);
  endproperty
  property p_stop; gen_stop |-> $past(wr & ~pwdata[2] & ~pwdata[0]);
  endproperty
  a_bsy_set: assert property (p_bsy_set) else $error("busy not set");
  a_bsy_clr: assert property (p_bsy_clr) else $error("busy kept");
  a_arb: assert property (p_arb) else $error("mode kept");
  a_rw: assert property (p_rw) else $error("rw not taken");
  a_nack: assert property (p_nack) else $error("stray ack status");
  a_halt: assert property (p_halt) else $error("stray halt");
  a_start: assert property (p_start) else $error("stray start");
  a_stop: assert property (p_stop) else $error("stray stop");
endmodule
bind i2cbc_ctrl i2cbc_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .scl_in(scl_in), .sda_in(sda_in),
  .arb_lost(arb_lost), .first_frame_done(first_frame_done),
  .rw_bit(rw_bit), .ack_valid(ack_valid), .ack_in(ack_in),
  .gen_start(gen_start), .gen_stop(gen_stop),
  .transfer_halt(transfer_halt), .ack_received_bit(ack_received_bit),
  .bus_busy_flag(bus_busy_flag), .mode(mode));

//--- tb/i2cbc_bus_model.sv
// other bus party making start and stop conditions
// lines are pulled up, so they idle high
`timescale 1ns/1ps
module i2cbc_bus_model (
  input  wire  pclk,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // fall=1 start, fall=0 stop, clock held high
  task automatic cond(input logic fall);
    @(posedge pclk) sda <= fall;
    repeat (2) @(posedge pclk);
    sda <= ~fall;
    repeat (3) @(posedge pclk);
  endtask
endmodule

//--- tb/test_i2cbc_ctrl.sv
// self-checking bench for the bus control block
// apb master task, bus model, engine pulses from here
`timescale 1ns/1ps
`include "i2cbc_defines.vh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
  miscompares++; $display("mismatch %s exp %h got %h", n, e, s); end end
module test_i2cbc_ctrl;
  logic pclk, presetn, psel, penable, pwrite, err, pready, pslverr;
  logic arb_lost, first_frame_done, rw_bit, ack_valid, ack_in, irq;
  logic gen_start, gen_stop, transfer_halt, ack_received_bit;
  logic bus_busy_flag, scl, sda, frame_done, irq_event;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  mode;
  int miscompares, compares, cyc, starts, stops;
  i2cbc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
    .sda_in(sda), .arb_lost(arb_lost), .first_frame_done(first_frame_done),
    .rw_bit(rw_bit), .frame_done(frame_done), .ack_valid(ack_valid),
    .ack_in(ack_in), .irq_event(irq_event), .irq(irq), .mode(mode),
    .gen_start(gen_start), .gen_stop(gen_stop),
    .transfer_halt(transfer_halt), .ack_received_bit(ack_received_bit),
    .bus_busy_flag(bus_busy_flag));
  i2cbc_bus_model bus (.pclk(pclk), .scl(scl), .sda(sda));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // pulses are counted mid-cycle, where they have settled
  always @(negedge pclk) begin
    starts += gen_start;
    stops += gen_stop;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      finish_test;
    end
  end
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] d);
    xfer(1'b0, `I2CBC_OFF_CTRL, 8'h00);
    xfer(1'b1, `I2CBC_OFF_CTRL, d);
  endtask
  task automatic pulse_ack(input logic v);
    @(posedge pclk) {ack_valid, ack_in} <= {1'b1, v};
    @(posedge pclk) ack_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic t_reset;
    xfer(1'b0, `I2CBC_OFF_CTRL, 8'h00);
    `CHK("ctrl", `I2CBC_CTRL_RESET, rd[7:0])
    xfer(1'b0, 12'h010, 8'h00);
    `CHK("slverr", 1'b1, err)
  endtask
  task automatic t_busy;
    bus.cond(1'b1);
    wr(8'h01);
    `CHK("busy", 1'b1, bus_busy_flag)
    xfer(1'b0, `I2CBC_OFF_CTRL, 8'h00);
    `CHK("busy bit", 1'b1, rd[2])
    bus.cond(1'b0);
    `CHK("busy", 1'b0, bus_busy_flag)
  endtask
  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      wr({2'h0, i[1:0], 4'h1});
      `CHK("mode", i[1:0], mode)
    end
    starts = 0;
    stops = 0;
    wr(8'h34);
    `CHK("starts", 1, starts)
    wr(8'h35);
    `CHK("starts", 1, starts)
    wr(8'h34);
    `CHK("starts", 2, starts)
    wr(8'h30);
    `CHK("stops", 1, stops)
  endtask
  task automatic t_arb;
    @(posedge pclk) arb_lost <= 1'b1;
    @(posedge pclk) arb_lost <= 1'b0;
    @(posedge pclk);
    `CHK("mode", 2'h0, mode)
    @(posedge pclk) {first_frame_done, rw_bit} <= 2'h3;
    @(posedge pclk) first_frame_done <= 1'b0;
    @(posedge pclk);
    `CHK("mode", 2'h1, mode)
    xfer(1'b1, `I2CBC_OFF_CTRL, 8'h31);
    `CHK("mode", 2'h1, mode)
    wr(8'h31);
    `CHK("mode", 2'h3, mode)
  endtask
  task automatic t_ack;
    wr(8'h41);
    pulse_ack(1'b1);
    `CHK("ack", 1'b0, ack_received_bit)
    `CHK("halt", 1'b0, transfer_halt)
    wr(8'h49);
    pulse_ack(1'b1);
    `CHK("ack", 1'b1, ack_received_bit)
    `CHK("halt", 1'b1, transfer_halt)
    `CHK("irq", 1'b1, irq)
    wr(8'h0b);
    `CHK("irq", 1'b0, irq)
    wr(8'h4b);
    `CHK("irq", 1'b1, irq)
    wr(8'h49);
    `CHK("irq", 1'b0, irq)
    @(posedge pclk) irq_event <= 1'b1;
    @(posedge pclk) irq_event <= 1'b0;
    xfer(1'b1, `I2CBC_OFF_CTRL, 8'h49);
    `CHK("irq", 1'b1, irq)
    wr(8'h49);
    `CHK("irq", 1'b0, irq)
  endtask
  task automatic t_frame;
    bus.cond(1'b1);
    wr(8'h11);
    `CHK("mode", 2'h0, mode)
    @(posedge pclk) frame_done <= 1'b1;
    @(posedge pclk) frame_done <= 1'b0;
    @(posedge pclk);
    `CHK("mode", 2'h1, mode)
    bus.cond(1'b0);
  endtask
  task finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {arb_lost, first_frame_done, rw_bit, ack_valid, ack_in} = '0;
    {frame_done, irq_event} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_busy;
    t_modes;
    t_arb;
    t_ack;
    t_frame;
    finish_test;
  end
endmodule
